/* pmev_event_flags.sv */
// latched event flags, summaries, live status and protective gating of a pmic
// assumes: live conditions are asynchronous; register port and measurement strobe
// are on clk; restore_defaults reloads the register banks kept outside this block
//
// Function
// RQ1: power-good pin going active to inactive sets top bit 7 until cleared.
// RQ2: top bit 6 reads set while linear event register is nonzero.
// RQ3: top bit 5 reads set while step-down event register is nonzero.
// RQ4: sync clock appearing or disappearing latches top bit 4.
// RQ5: thermal shutdown latches top bit 3, disables regulators, drives both outputs low.
// RQ6: while thermal shutdown flag is set, regulators stay disabled.
// RQ7: thermal warning latches top bit 2 without touching regulator operation.
// RQ8: input over-voltage latches top bit 1, disables regulators, outputs low.
// RQ9: new load-current measurement result latches top bit 0.
// RQ10: supply undervoltage or software reset restores defaults then latches 0x1A bit 0.
// RQ11: step-down power-good events latch bits 6 and 2 of 0x1B.
// RQ12: step-down output short beyond 1 ms latches bits 5 and 1.
// RQ13: step-down current limit activity latches bits 4 and 0.
// RQ14: flags clear only by writing one; all reset to zero. The code also clears them while a restore runs.
// RQ15: live shutdown, warning and over-voltage shown apart in status register.
// RQ16: linear regulators latch good, short and limit flags, cleared by one.
// RQ17: writing zero, summary or reserved bits leaves stored flags unchanged.
// RQ18: an event in the clearing cycle keeps its flag set.
`timescale 1ns/1ps
`include "pmev_consts.svh"

module pmev_event_flags #(
   parameter int SHORT_CYCLES = `PMEV_SHORT_CYCLES,
   parameter int CNT_W        = 18
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // register port from the serial interface
   input  wire pmev_pkg::pmev_reg_req_t reg_req,
   output logic [7:0]                 reg_rdata,
   output logic                       reg_rvalid,
   // conditions from pins and analog blocks
   input  wire pmev_pkg::pmev_live_t  live_in,
   input  wire logic                  meas_done,
   // requested enables and general outputs from configuration
   input  wire logic [3:0]            regulator_enable_request,
   input  wire logic [1:0]            general_output_request,
   // gated controls and the restore indication
   output logic [3:0]                 regulator_enable,
   output logic                       general_output_a,
   output logic                       general_output_b,
   output logic                       restore_defaults
);

   // refused at elaboration: the counter must hold the whole qualification time
   if (SHORT_CYCLES < 2 || SHORT_CYCLES >= (2 ** CNT_W) - 1) begin
      $error("short-circuit count does not fit the counter");
   end

   typedef logic [CNT_W-1:0] pmev_cnt_t;

   // set wins over clear; only writable bits can ever be stored
   function automatic logic [7:0] w1c(input logic [7:0] old, input logic [7:0] set,
                                      input logic [7:0] clr, input logic [7:0] mask);
      w1c = ((old & ~clr) | set) & mask;
   endfunction

   // synchroniser and edge history
   pmev_pkg::pmev_live_t sync1_reg;
   pmev_pkg::pmev_live_t sync2_reg;
   pmev_pkg::pmev_live_t prev_reg;
   logic [1:0]           prime_reg;
   logic [1:0]           prime_next;
   logic                 primed;

   // flag storage
   logic [7:0] top_reg;
   logic [7:0] top_next;
   logic [7:0] rst_flags_reg;
   logic [7:0] rst_flags_next;
   logic [7:0] step_reg;
   logic [7:0] step_next;
   logic [7:0] linear_reg;
   logic [7:0] linear_next;
   logic       restore_prev_reg;
   pmev_cnt_t  short_cnt_reg  [4];
   pmev_cnt_t  short_cnt_next [4];

   // outputs
   logic [7:0] rdata_next;
   logic       rvalid_next;
   logic [3:0] reg_en_next;
   logic       gpo_a_next;
   logic       gpo_b_next;

   // events and decodes
   logic       software_reset_command_cmd;
   logic       restore;
   logic [3:0] good_fall;
   logic [3:0] short_evt;
   logic [7:0] top_set;
   logic [7:0] step_set;
   logic [7:0] linear_set;
   logic [7:0] top_clr;
   logic [7:0] rst_clr;
   logic [7:0] step_clr;
   logic [7:0] linear_clr;
   logic [7:0] top_view;
   logic [7:0] status_view;
   logic       shutdown;

   // two flops before any logic looks at a pin or analog level
   // prev_reg keeps the sample before, for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg  <= '0;
         prime_reg <= 2'h0;
      end else begin
         sync1_reg <= live_in;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
         prime_reg <= prime_next;
      end
   end

   // edges are ignored until the synchroniser holds real samples
   always_comb begin
      prime_next = (prime_reg == 2'h3) ? prime_reg : prime_reg + 2'h1;
      primed     = (prime_reg == 2'h3);
   end

   // short-circuit qualification counters, one per regulator
   // the count stops at the limit, so a held short keeps setting its flag
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         short_cnt_next[i] = short_cnt_reg[i];
         short_evt[i]      = 1'b0;
         if (!sync2_reg.reg_short[i]) begin
            short_cnt_next[i] = '0;
         end else if (short_cnt_reg[i] == pmev_cnt_t'(SHORT_CYCLES)) begin
            short_evt[i] = 1'b1; // see RQ12 see RQ16
         end else begin
            short_cnt_next[i] = short_cnt_reg[i] + pmev_cnt_t'(1);
         end
         good_fall[i] = primed && prev_reg.reg_good[i] && !sync2_reg.reg_good[i];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            short_cnt_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            short_cnt_reg[i] <= short_cnt_next[i];
         end
      end
   end

   // event sources and host clears
   always_comb begin
      software_reset_command_cmd = reg_req.wr && (reg_req.addr == `PMEV_ADDR_SOFTWARE_RESET_COMMAND)
                     && reg_req.wdata[`PMEV_SOFTWARE_RESET_COMMAND_BIT];
      // supply dip and software command share one restore path
      restore      = software_reset_command_cmd || sync2_reg.supply_low;

      top_set = 8'h00;
      top_set[`PMEV_TOP_POWER_GOOD_OUTPUT_FALL] = primed && prev_reg.power_good_output_active
                                      && !sync2_reg.power_good_output_active;            // see RQ1
      top_set[`PMEV_TOP_CLK_CHANGE] = primed
                                      && (prev_reg.clk_valid != sync2_reg.clk_valid); // see RQ4
      top_set[`PMEV_TOP_THERM_SD]   = sync2_reg.therm_sd;                     // see RQ5
      top_set[`PMEV_TOP_THERM_WARN] = sync2_reg.therm_warn;                   // see RQ7
      top_set[`PMEV_TOP_OVERVOLT]   = sync2_reg.overvolt;                     // see RQ8
      top_set[`PMEV_TOP_MEAS_DONE]  = meas_done;                              // see RQ9

      step_set   = 8'h00;
      linear_set = 8'h00;
      // regulator a in the low nibble, b in the high one
      for (int r = 0; r < 2; r++) begin
         // see RQ11 see RQ12 see RQ13
         step_set[r*`PMEV_GRP_B_OFFSET + `PMEV_GRP_GOOD]    = good_fall[r];
         step_set[r*`PMEV_GRP_B_OFFSET + `PMEV_GRP_SHORT]   = short_evt[r];
         step_set[r*`PMEV_GRP_B_OFFSET + `PMEV_GRP_LIMIT]   = sync2_reg.reg_limit[r];
         // see RQ16
         linear_set[r*`PMEV_GRP_B_OFFSET + `PMEV_GRP_GOOD]  = good_fall[r+2];
         linear_set[r*`PMEV_GRP_B_OFFSET + `PMEV_GRP_SHORT] = short_evt[r+2];
         linear_set[r*`PMEV_GRP_B_OFFSET + `PMEV_GRP_LIMIT] = sync2_reg.reg_limit[r+2];
      end

      // a zero in the written byte clears nothing
      top_clr    = (reg_req.wr && reg_req.addr == `PMEV_ADDR_TOP_EVENTS)
                   ? reg_req.wdata : 8'h00;                                   // see RQ17
      rst_clr    = (reg_req.wr && reg_req.addr == `PMEV_ADDR_RESET_EVENTS)
                   ? reg_req.wdata : 8'h00;
      step_clr   = (reg_req.wr && reg_req.addr == `PMEV_ADDR_STEP_EVENTS)
                   ? reg_req.wdata : 8'h00;
      linear_clr = (reg_req.wr && reg_req.addr == `PMEV_ADDR_LINEAR_EVENTS)
                   ? reg_req.wdata : 8'h00;
   end

   // flag next values
   always_comb begin
      // summaries and reserved bits are masked out, so writes there do nothing
      top_next    = w1c(top_reg, top_set, top_clr, `PMEV_TOP_W1C_MASK);   // see RQ14 see RQ18
      step_next   = w1c(step_reg, step_set, step_clr, `PMEV_GRP_W1C_MASK); // see RQ17
      linear_next = w1c(linear_reg, linear_set, linear_clr, `PMEV_GRP_W1C_MASK);
      rst_flags_next = w1c(rst_flags_reg,
                           {7'h00, restore_prev_reg && !restore},
                           rst_clr, `PMEV_RESET_W1C_MASK);
      // defaults restored while a reset runs; its own flag is set as it ends
      if (restore) begin
         top_next       = `PMEV_FLAGS_RESET;                                  // see RQ10
         step_next      = `PMEV_FLAGS_RESET;
         linear_next    = `PMEV_FLAGS_RESET;
         rst_flags_next = `PMEV_FLAGS_RESET;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         top_reg          <= `PMEV_FLAGS_RESET; // see RQ14
         rst_flags_reg    <= `PMEV_FLAGS_RESET;
         step_reg         <= `PMEV_FLAGS_RESET;
         linear_reg       <= `PMEV_FLAGS_RESET;
         restore_prev_reg <= 1'b0;
      end else begin
         top_reg          <= top_next;
         rst_flags_reg    <= rst_flags_next;
         step_reg         <= step_next;
         linear_reg       <= linear_next;
         restore_prev_reg <= restore;
      end
   end

   // read views and protective gating
   always_comb begin
      // summaries follow the group registers, so they clear by themselves
      top_view = top_reg;
      top_view[`PMEV_TOP_LINEAR_SUM] = (linear_reg != 8'h00);                 // see RQ2
      top_view[`PMEV_TOP_STEP_SUM]   = (step_reg != 8'h00);                   // see RQ3

      // live conditions kept apart from the latched ones
      status_view = 8'h00;
      status_view[`PMEV_STAT_POWER_GOOD_OUTPUT]       = sync2_reg.power_good_output_active;           // see RQ15
      status_view[`PMEV_STAT_CLK_INVALID] = !sync2_reg.clk_valid;
      status_view[`PMEV_STAT_THERM_SD]    = sync2_reg.therm_sd;
      status_view[`PMEV_STAT_THERM_WARN]  = sync2_reg.therm_warn;
      status_view[`PMEV_STAT_OVERVOLT]    = sync2_reg.overvolt;

      rdata_next  = reg_rdata;
      rvalid_next = reg_req.rd;
      if (reg_req.rd) begin
         case (reg_req.addr)
            `PMEV_ADDR_TOP_EVENTS:    rdata_next = top_view;
            `PMEV_ADDR_RESET_EVENTS:  rdata_next = rst_flags_reg;
            `PMEV_ADDR_STEP_EVENTS:   rdata_next = step_reg;
            `PMEV_ADDR_LINEAR_EVENTS: rdata_next = linear_reg;
            `PMEV_ADDR_TOP_STATUS:    rdata_next = status_view;
            default:                  rdata_next = 8'h00;
         endcase
      end
   end

   // protective gating, one edge behind the synchronised condition
   always_comb begin
      // thermal warning deliberately absent here: it only reports
      shutdown = sync2_reg.therm_sd || sync2_reg.overvolt                      // see RQ5 see RQ8
                 || top_reg[`PMEV_TOP_THERM_SD]                                // see RQ6
                 || restore;                                                   // see RQ10
      reg_en_next = shutdown ? 4'h0 : regulator_enable_request;                // see RQ7
      gpo_a_next  = !shutdown && general_output_request[0];
      gpo_b_next  = !shutdown && general_output_request[1];
   end

   // read port: data holds until the next read, valid lasts one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata  <= rdata_next;
         reg_rvalid <= rvalid_next;
      end
   end

   // gated controls and the restore indication
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regulator_enable <= 4'h0;
         general_output_a <= 1'b0;
         general_output_b <= 1'b0;
         restore_defaults <= 1'b0;
      end else begin
         regulator_enable <= reg_en_next;
         general_output_a <= gpo_a_next;
         general_output_b <= gpo_b_next;
         restore_defaults <= restore;
      end
   end

endmodule

/* pmev_consts.svh */
// offsets, field positions, reset values and timing counts for the event flag block
// assumes: included by the event flag package users; definitions only
`ifndef PMEV_CONSTS_SVH
`define PMEV_CONSTS_SVH

// register offsets on the internal register port
`define PMEV_ADDR_SOFTWARE_RESET_COMMAND      8'h18
`define PMEV_ADDR_TOP_EVENTS    8'h19
`define PMEV_ADDR_RESET_EVENTS  8'h1A
`define PMEV_ADDR_STEP_EVENTS   8'h1B
`define PMEV_ADDR_LINEAR_EVENTS 8'h1C
`define PMEV_ADDR_TOP_STATUS    8'h1D

// top event register fields
`define PMEV_TOP_POWER_GOOD_OUTPUT_FALL     7
`define PMEV_TOP_LINEAR_SUM     6
`define PMEV_TOP_STEP_SUM       5
`define PMEV_TOP_CLK_CHANGE     4
`define PMEV_TOP_THERM_SD       3
`define PMEV_TOP_THERM_WARN     2
`define PMEV_TOP_OVERVOLT       1
`define PMEV_TOP_MEAS_DONE      0
`define PMEV_TOP_W1C_MASK       8'h9F

// reset event register and software reset command
`define PMEV_RESET_FLAG_BIT     0
`define PMEV_RESET_W1C_MASK     8'h01
`define PMEV_SOFTWARE_RESET_COMMAND_BIT       0

// per-regulator group register: regulator b in the upper nibble, a in the lower
`define PMEV_GRP_GOOD           2
`define PMEV_GRP_SHORT          1
`define PMEV_GRP_LIMIT          0
`define PMEV_GRP_B_OFFSET       4
`define PMEV_GRP_W1C_MASK       8'h77

// live status register fields
`define PMEV_STAT_POWER_GOOD_OUTPUT         7
`define PMEV_STAT_CLK_INVALID   4
`define PMEV_STAT_THERM_SD      3
`define PMEV_STAT_THERM_WARN    2
`define PMEV_STAT_OVERVOLT      1

`define PMEV_FLAGS_RESET        8'h00

// short-circuit qualification time
`define PMEV_SHORT_TIME_US      1000
`define PMEV_CLK_MHZ            200
`define PMEV_SHORT_CYCLES       (`PMEV_SHORT_TIME_US * `PMEV_CLK_MHZ)

`endif

/* pmev_pkg.sv */
// types shared by the event flag block
// assumes: constants come from pmev_consts.svh
package pmev_pkg;

   // register access from the serial interface, same clock as the block
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pmev_reg_req_t;

   // analog and pin conditions; index 0,1 step-down a,b; 2,3 linear a,b
   typedef struct packed {
      logic       power_good_output_active;
      logic       clk_valid;
      logic       therm_sd;
      logic       therm_warn;
      logic       overvolt;
      logic       supply_low;
      logic [3:0] reg_good;
      logic [3:0] reg_short;
      logic [3:0] reg_limit;
   } pmev_live_t;

endpackage

/* pmev_event_flags_monitor.sv */
// concurrent checks on the event flag block ports
// assumes: bound into pmev_event_flags; one clock, async active-low reset
`timescale 1ns/1ps
module pmev_event_flags_monitor #(
   parameter int SHORT_CYCLES = 20,
   parameter int CNT_W        = 18
) (
   // clock and reset
   input logic                    clk,
   input logic                    rst_n,
   // register port
   input pmev_pkg::pmev_reg_req_t reg_req,
   input logic [7:0]              reg_rdata,
   input logic                    reg_rvalid,
   // conditions and requests
   input pmev_pkg::pmev_live_t    live_in,
   input logic                    meas_done,
   input logic [3:0]              regulator_enable_request,
   input logic [1:0]              general_output_request,
   // gated controls and the restore indication
   input logic [3:0]              regulator_enable,
   input logic                    general_output_a,
   input logic                    general_output_b,
   input logic                    restore_defaults
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // four samples: two sync stages plus the gating register
   property p_sd_off;
      live_in.therm_sd[*4] |-> regulator_enable == 4'h0 && !general_output_a && !general_output_b;
   endproperty
   a_sd_off: assert property (p_sd_off) else $error("enable live in shutdown");
   property p_ov_off;
      live_in.overvolt[*4] |-> regulator_enable == 4'h0 && !general_output_a && !general_output_b;
   endproperty
   a_ov_off: assert property (p_ov_off) else $error("enable live in overvoltage");
   property p_supply_off;
      live_in.supply_low[*4] |-> regulator_enable == 4'h0;
   endproperty
   a_supply_off: assert property (p_supply_off) else $error("enable in supply low");
   property p_en_subset;
      (regulator_enable & ~$past(regulator_enable_request)) == 4'h0;
   endproperty
   a_en_subset: assert property (p_en_subset) else $error("enable not requested");
   // latched shutdown keeps enables off after the live condition has gone
   property p_sd_latched;
      live_in.therm_sd[*4] ##1 (!live_in.therm_sd && !reg_req.wr && !live_in.supply_low)[*8]
         |-> regulator_enable == 4'h0;
   endproperty
   a_sd_latched: assert property (p_sd_latched) else $error("enable while flag set");
   property p_sw_restore;
      reg_req.wr && reg_req.addr == 8'h18 && reg_req.wdata[0] |-> ##[1:4] restore_defaults;
   endproperty
   a_sw_restore: assert property (p_sw_restore) else $error("no restore");
   property p_ovp_live;
      live_in.overvolt[*4] ##0 (reg_req.rd && reg_req.addr == 8'h1D) |=> reg_rdata[1];
   endproperty
   a_ovp_live: assert property (p_ovp_live) else $error("live status wrong");
   property p_meas_read;
      meas_done ##1 (reg_req.rd && reg_req.addr == 8'h19) |=> reg_rdata[0];
   endproperty
   a_meas_read: assert property (p_meas_read) else $error("measure flag lost");
   property p_reset_quiet;
      $rose(rst_n) |-> regulator_enable == 4'h0 && !restore_defaults && !reg_rvalid;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
endmodule

bind pmev_event_flags pmev_event_flags_monitor #(.SHORT_CYCLES(SHORT_CYCLES), .CNT_W(CNT_W))
   u_mon (.clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .live_in(live_in), .meas_done(meas_done),
   .regulator_enable_request(regulator_enable_request),
   .general_output_request(general_output_request), .regulator_enable(regulator_enable),
   .general_output_a(general_output_a), .general_output_b(general_output_b),
   .restore_defaults(restore_defaults));

/* pmev_host_model.sv */
// host side of the register port: byte writes and reads
// assumes: callers resume just after a rising edge of clk
`timescale 1ns/1ps
module pmev_host_model (
   input  logic                    clk,
   output pmev_pkg::pmev_reg_req_t req,
   input  logic [7:0]              rdata,
   input  logic                    rvalid
);
   int idle = 0;
   initial req = '0;
   // released address and data show the inverse, never the stale value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      repeat (idle) @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      repeat (idle) @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, 8'hFF};
      @(posedge clk);
      d = rvalid ? rdata : 8'hXX;
   endtask
endmodule

/* tb.sv */
// self-checking bench for the event flag block driven by the host model
// assumes: package, host model and checker compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
   localparam int SC = 20;
   logic                    clk = 1'b0;
   logic                    rst_n = 1'b0;
   pmev_pkg::pmev_reg_req_t req;
   pmev_pkg::pmev_live_t    live;
   logic [7:0]              rdata, d;
   logic                    rvalid, rst_out, go_a, go_b;
   logic                    meas = 1'b0;
   logic [3:0]              en;
   logic [3:0]              en_req = 4'h0;
   logic [1:0]              go_req = 2'b00;
   int                      errors = 0;
   int                      total_checks = 0;
   always #2.5 clk = ~clk;
   pmev_event_flags #(.SHORT_CYCLES(SC)) uut (.clk(clk), .rst_n(rst_n), .reg_req(req),
      .reg_rdata(rdata), .reg_rvalid(rvalid), .live_in(live), .meas_done(meas),
      .regulator_enable_request(en_req), .general_output_request(go_req),
      .regulator_enable(en), .general_output_a(go_a), .general_output_b(go_b),
      .restore_defaults(rst_out));
   pmev_host_model host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, d);
      `CHK(d, e)
   endtask
   task automatic end_sim;
      if (errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_meas;
      meas <= 1'b1;
      @(posedge clk);
      meas <= 1'b0;
      rchk(8'h19, 8'h01);
      host.wr(8'h19, 8'h60);
      host.wr(8'h19, 8'h00);
      rchk(8'h19, 8'h01);
      // event in the clearing cycle must survive
      fork
         host.wr(8'h19, 8'h01);
         begin
            meas <= 1'b1;
            @(posedge clk);
            meas <= 1'b0;
         end
      join
      rchk(8'h19, 8'h01);
      host.wr(8'h19, 8'h01);
      rchk(8'h19, 8'h00);
   endtask
   task automatic t_top;
      en_req <= 4'hF;
      live.power_good_output_active <= 1'b0;
      live.clk_valid <= 1'b0;
      live.therm_warn <= 1'b1;
      cyc(6);
      `CHK(en, 4'hF)
      live.therm_warn <= 1'b0;
      cyc(4);
      rchk(8'h19, 8'h94);
      host.wr(8'h19, 8'h94);
      live.power_good_output_active <= 1'b1;
      live.clk_valid <= 1'b1;
      cyc(6);
      rchk(8'h19, 8'h10);
      host.wr(8'h19, 8'h10);
   endtask
   task automatic t_groups;
      live.reg_good <= 4'b1000;
      live.reg_limit <= 4'b0011;
      cyc(5);
      live.reg_limit <= 4'h0;
      live.reg_good <= 4'hF;
      cyc(5);
      rchk(8'h1B, 8'h55);
      rchk(8'h1C, 8'h04);
      rchk(8'h19, 8'h60);
      host.wr(8'h1B, 8'h04);
      rchk(8'h1B, 8'h51);
      host.wr(8'h1B, 8'h51);
      rchk(8'h19, 8'h40);
      host.wr(8'h1C, 8'h04);
      rchk(8'h19, 8'h00);
   endtask
   task automatic t_short;
      live.reg_short <= 4'b1010;
      cyc(SC - 5);
      live.reg_short <= 4'h0;
      cyc(4);
      rchk(8'h1B, 8'h00);
      live.reg_short <= 4'b1010;
      cyc(SC + 8);
      live.reg_short <= 4'h0;
      cyc(4);
      rchk(8'h1B, 8'h20);
      rchk(8'h1C, 8'h20);
      host.wr(8'h1B, 8'h20);
      host.wr(8'h1C, 8'h20);
      rchk(8'h19, 8'h00);
   endtask
   task automatic t_sd;
      go_req <= 2'b11;
      live.therm_sd <= 1'b1;
      cyc(6);
      `CHK({en, go_a, go_b}, 6'h00)
      live.therm_sd <= 1'b0;
      cyc(6);
      `CHK(en, 4'h0)
      rchk(8'h1D, 8'h80);
      rchk(8'h19, 8'h08);
      host.wr(8'h19, 8'h08);
      cyc(3);
      `CHK({en, go_a, go_b}, 6'h3F)
   endtask
   task automatic t_ovp;
      live.overvolt <= 1'b1;
      cyc(6);
      rchk(8'h1D, 8'h82);
      `CHK(en, 4'h0)
      host.wr(8'h19, 8'h02);
      rchk(8'h19, 8'h02);
      live.overvolt <= 1'b0;
      cyc(4);
      host.wr(8'h19, 8'h02);
      rchk(8'h19, 8'h00);
      `CHK(en, 4'hF)
   endtask
   // software command first, then supply dip with a slow host
   task automatic t_restore;
      int n;
      for (int i = 0; i < 2; i++) begin
         host.idle = 2 * i;
         meas <= 1'b1;
         @(posedge clk);
         meas <= 1'b0;
         if (i == 0) host.wr(8'h18, 8'h01);
         else begin
            live.supply_low <= 1'b1;
            cyc(6);
            live.supply_low <= 1'b0;
         end
         n = 0;
         while (rst_out !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
         end
         `CHK(rst_out, 1'b1)
         while (rst_out !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
         end
         `CHK(n < 200, 1'b1)
         cyc(2);
         rchk(8'h19, 8'h00);
         host.wr(8'h1A, 8'hFE);
         rchk(8'h1A, 8'h01);
         host.wr(8'h1A, 8'h01);
         rchk(8'h1A, 8'h00);
      end
      host.idle = 0;
      rchk(8'h18, 8'h00);
      rchk(8'h30, 8'h00);
   endtask
   initial begin
      live = '0;
      live.power_good_output_active = 1'b1;
      live.clk_valid = 1'b1;
      live.reg_good = 4'hF;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      cyc(6);
      for (int a = 8'h19; a <= 8'h1C; a++) rchk(8'(a), 8'h00);
      t_meas();
      t_top();
      t_groups();
      t_short();
      t_sd();
      t_ovp();
      t_restore();
      end_sim();
   end
   // whole run is well under a thousand cycles; this margin means a hang
   initial begin
      #100000;
      errors++;
      end_sim();
   end
endmodule
